//--- logic/asr_params.svh
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// apb byte offsets, one aligned word each
`define ASR_OFS_RESULT    12'h000
`define ASR_OFS_CONFIG    12'h004
`define ASR_OFS_STATUS    12'h008
`define ASR_OFS_CALZERO   12'h00c
`define ASR_OFS_CALFULL   12'h010

// serial register select codes
`define ASR_SEL_COMM      3'h0
`define ASR_SEL_MODE      3'h1
`define ASR_SEL_FILT_HI   3'h2
`define ASR_SEL_FILT_LO   3'h3
`define ASR_SEL_TEST      3'h4
`define ASR_SEL_DATA      3'h5
`define ASR_SEL_ZCAL      3'h6
`define ASR_SEL_FCAL      3'h7

// reset values
`define ASR_RST_COMM      7'h04
`define ASR_RST_MODE      8'h00
`define ASR_RST_FILT_HI   8'h00
`define ASR_RST_FILT_LO   8'h00
`define ASR_RST_TEST      8'h00
`define ASR_RST_CAL       24'h000000
`define ASR_RST_RESULT    24'h000000

// field positions
`define ASR_COMM_RW       3
`define ASR_FHI_WL        6
`define ASR_STAT_READY_N  3

// serial lengths and counts
`define ASR_LEN_BYTE      5'h08
`define ASR_LEN_SHORT     5'h10
`define ASR_LEN_LONG      5'h18
`define ASR_COMM_LAST     5'h07
`define ASR_ONES_LAST     6'h1f

`endif

//--- logic/asr_pkg.sv
package asr_pkg;

  // serial interface sequencing
  typedef enum logic [1:0] {
    ASR_ST_COMM = 2'b00,
    ASR_ST_WR   = 2'b01,
    ASR_ST_RD   = 2'b10
  } asr_state_t;

  typedef logic [23:0] asr_word_t;
  typedef logic [1:0]  asr_pair_t;

endpackage

//--- logic/asr_serial_regs.sv
`include "asr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module asr_serial_regs
  import asr_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          sclk,
  input  wire logic          din,
  output logic               dout,
  output logic               conversion_ready_flag_n,
  output logic      [2:0]    cfg_channel,
  output logic      [7:0]    cfg_mode,
  output logic      [7:0]    cfg_filter_hi,
  output logic      [7:0]    cfg_filter_lo,
  output logic      [23:0]   cfg_cal_zero,
  output logic      [23:0]   cfg_cal_full
);

  // serial domain state
  asr_state_t  state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [5:0]  ones_reg, ones_next;
  asr_word_t   shift_reg, shift_next;
  logic        dout_next;
  logic [6:0]  comm_reg, comm_next;
  logic [7:0]  mode_reg, mode_next;
  logic [7:0]  fhi_reg, fhi_next;
  logic [7:0]  flo_reg, flo_next;
  logic [7:0]  test_reg, test_next;
  asr_word_t   zcal_reg [3];
  asr_word_t   zcal_next [3];
  asr_word_t   fcal_reg [3];
  asr_word_t   fcal_next [3];
  asr_word_t   hold_reg, hold_next;
  logic        seen_res_reg, seen_res_next;
  logic        cfg_tgl_reg, cfg_tgl_next;
  logic        rd_tgl_reg, rd_tgl_next;
  logic [1:0]  to_link_s;
  // core domain state
  asr_word_t   res_reg, res_next;
  logic        res_tgl_reg, res_tgl_next;
  logic        ready_n_next;
  logic        seen_cfg_reg, seen_cfg_next;
  logic        seen_rd_reg, seen_rd_next;
  logic [1:0]  to_core_s;
  logic [2:0]  chan_next;
  logic [7:0]  cmode_next, cfhi_next, cflo_next;
  asr_word_t   czero_next, cfull_next;
  logic [31:0] prdata_next;
  logic        pready_next, pslverr_next;
  // helpers
  logic [6:0]  comm_bits;
  logic        comm_done;
  logic        ones_hit;
  logic [4:0]  len_new, len_cur;
  asr_word_t   aligned;
  asr_word_t   wr_word;
  asr_pair_t   pair_cur;
  logic        setup, access, mapped;

  // channel code to calibration pair
  function automatic asr_pair_t pair_of(input logic [2:0] ch);
    pair_of = 2'h0;
    unique case (ch)
      3'h0, 3'h4:             pair_of = 2'h0;
      3'h1, 3'h5:             pair_of = 2'h1;
      3'h2, 3'h3, 3'h6, 3'h7: pair_of = 2'h2;
    endcase
  endfunction

  // access length of each register
  function automatic logic [4:0] len_of(input logic [2:0] sel);
    len_of = `ASR_LEN_BYTE;
    unique case (sel)
      `ASR_SEL_COMM, `ASR_SEL_MODE, `ASR_SEL_FILT_HI, `ASR_SEL_FILT_LO,
      `ASR_SEL_TEST: len_of = `ASR_LEN_BYTE;
      `ASR_SEL_DATA: len_of = fhi_reg[`ASR_FHI_WL] ? `ASR_LEN_LONG : `ASR_LEN_SHORT;
      `ASR_SEL_ZCAL, `ASR_SEL_FCAL: len_of = `ASR_LEN_LONG;
    endcase
  endfunction

  // read value right aligned
  function automatic asr_word_t read_value(input logic [6:0] comm);
    read_value = 24'h000000;
    unique case (comm[6:4])
      `ASR_SEL_COMM:    read_value = {16'h0000, to_link_s[1], comm};
      `ASR_SEL_MODE:    read_value = {16'h0000, mode_reg};
      `ASR_SEL_FILT_HI: read_value = {16'h0000, fhi_reg};
      `ASR_SEL_FILT_LO: read_value = {16'h0000, flo_reg};
      `ASR_SEL_TEST:    read_value = {16'h0000, test_reg};
      `ASR_SEL_DATA:    read_value = fhi_reg[`ASR_FHI_WL] ? hold_reg
                                     : {8'h00, hold_reg[23:8]};
      `ASR_SEL_ZCAL:    read_value = zcal_reg[pair_of(comm[2:0])];
      `ASR_SEL_FCAL:    read_value = fcal_reg[pair_of(comm[2:0])];
    endcase
  endfunction

  // serial decode helpers
  assign comm_bits = {shift_reg[5:0], din};
  assign ones_hit  = din && (ones_reg == `ASR_ONES_LAST) && (state_reg != ASR_ST_RD);
  assign comm_done = (state_reg == ASR_ST_COMM) && (cnt_reg == `ASR_COMM_LAST) && !ones_hit;
  assign wr_word   = {shift_reg[22:0], din};
  assign pair_cur  = pair_of(comm_reg[2:0]);

  // access lengths and the read word, re-evaluated on every register they read
  always_comb begin
    len_new = len_of(comm_bits[6:4]);
    len_cur = len_of(comm_reg[6:4]);
    aligned = read_value(comm_bits) << (5'd24 - len_new);
  end

  // new result toggle and ready level into link domain
  asr_sync #(.W(2)) u_sync_link (
    .clk      (sclk),
    .rst_b    (rst_b),
    .d        ({conversion_ready_flag_n, res_tgl_reg}),
    .sync_reg (to_link_s)
  );

  // serial transaction sequencer and register file
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    dout_next     = dout;
    comm_next     = comm_reg;
    mode_next     = mode_reg;
    fhi_next      = fhi_reg;
    flo_next      = flo_reg;
    test_next     = test_reg;
    zcal_next     = zcal_reg;
    fcal_next     = fcal_reg;
    cfg_tgl_next  = cfg_tgl_reg;
    rd_tgl_next   = rd_tgl_reg;
    hold_next     = hold_reg;
    seen_res_next = seen_res_reg;
    ones_next     = (din && state_reg != ASR_ST_RD) ? ones_reg + 6'd1 : 6'h00;
    if (to_link_s[0] != seen_res_reg) begin
      seen_res_next = to_link_s[0];
      hold_next     = res_reg;
    end
    unique case (state_reg)
      ASR_ST_COMM: begin
        if (cnt_reg == 5'h00) begin
          if (!din) begin
            cnt_next = 5'h01;
          end
        end else if (cnt_reg == `ASR_COMM_LAST) begin
          comm_next    = comm_bits;
          cfg_tgl_next = ~cfg_tgl_reg;
          cnt_next     = 5'h00;
          if (comm_bits[`ASR_COMM_RW]) begin
            state_next = ASR_ST_RD;
            shift_next = aligned;
            dout_next  = aligned[23];
          end else if (comm_bits[6:4] != `ASR_SEL_COMM) begin
            state_next = ASR_ST_WR;
          end
        end else begin
          cnt_next   = cnt_reg + 5'd1;
          shift_next = wr_word;
        end
      end
      ASR_ST_WR: begin
        shift_next = wr_word;
        if (cnt_reg == len_cur - 5'd1) begin
          state_next   = ASR_ST_COMM;
          cnt_next     = 5'h00;
          cfg_tgl_next = ~cfg_tgl_reg;
          unique case (comm_reg[6:4])
            `ASR_SEL_MODE:    mode_next = wr_word[7:0];
            `ASR_SEL_FILT_HI: fhi_next  = wr_word[7:0];
            `ASR_SEL_FILT_LO: flo_next  = wr_word[7:0];
            `ASR_SEL_TEST:    test_next = wr_word[7:0];
            `ASR_SEL_ZCAL:    zcal_next[pair_cur] = wr_word;
            `ASR_SEL_FCAL:    fcal_next[pair_cur] = wr_word;
            `ASR_SEL_COMM, `ASR_SEL_DATA: cfg_tgl_next = cfg_tgl_reg;
          endcase
        end else begin
          cnt_next = cnt_reg + 5'd1;
        end
      end
      ASR_ST_RD: begin
        if (cnt_reg == len_cur - 5'd1) begin
          state_next = ASR_ST_COMM;
          cnt_next   = 5'h00;
          dout_next  = 1'b1;
          if (comm_reg[6:4] == `ASR_SEL_DATA) begin
            rd_tgl_next = ~rd_tgl_reg;
          end
        end else begin
          cnt_next   = cnt_reg + 5'd1;
          shift_next = {shift_reg[22:0], 1'b0};
          dout_next  = shift_reg[22];
        end
      end
      default: begin
        state_next = ASR_ST_COMM;
        cnt_next   = 5'h00;
      end
    endcase
    // long run of ones resynchronises the interface
    if (ones_hit) begin
      state_next = ASR_ST_COMM;
      cnt_next   = 5'h00;
      ones_next  = 6'h00;
      dout_next  = 1'b1;
    end
  end

  // link domain registers
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ASR_ST_COMM;
      cnt_reg      <= 5'h00;
      ones_reg     <= 6'h00;
      shift_reg    <= 24'h000000;
      dout         <= 1'b1;
      comm_reg     <= `ASR_RST_COMM;
      mode_reg     <= `ASR_RST_MODE;
      fhi_reg      <= `ASR_RST_FILT_HI;
      flo_reg      <= `ASR_RST_FILT_LO;
      test_reg     <= `ASR_RST_TEST;
      for (int i = 0; i < 3; i++) begin
        zcal_reg[i] <= `ASR_RST_CAL;
        fcal_reg[i] <= `ASR_RST_CAL;
      end
      hold_reg     <= `ASR_RST_RESULT;
      seen_res_reg <= 1'b0;
      cfg_tgl_reg  <= 1'b0;
      rd_tgl_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      ones_reg     <= ones_next;
      shift_reg    <= shift_next;
      dout         <= dout_next;
      comm_reg     <= comm_next;
      mode_reg     <= mode_next;
      fhi_reg      <= fhi_next;
      flo_reg      <= flo_next;
      test_reg     <= test_next;
      zcal_reg     <= zcal_next;
      fcal_reg     <= fcal_next;
      hold_reg     <= hold_next;
      seen_res_reg <= seen_res_next;
      cfg_tgl_reg  <= cfg_tgl_next;
      rd_tgl_reg   <= rd_tgl_next;
    end
  end

  // serial sequence checks
  sequence s_read_start;
    comm_done && comm_bits[`ASR_COMM_RW] && (len_new == `ASR_LEN_BYTE);
  endsequence
  sequence s_byte_out;
    (state_reg == ASR_ST_RD) [*8] ##1 (state_reg == ASR_ST_COMM);
  endsequence

  a_gate_hold: assert property (
    @(posedge sclk) disable iff (!rst_b)
    (state_reg == ASR_ST_COMM && cnt_reg == 5'h00 && din) |=>
      (state_reg == ASR_ST_COMM && cnt_reg == 5'h00))
    else $error("leading one did not hold the comms bit position");
  a_comm_dir: assert property (
    @(posedge sclk) disable iff (!rst_b)
    (comm_done && comm_bits[`ASR_COMM_RW]) |=> (state_reg == ASR_ST_RD))
    else $error("read direction not taken after comms write");
  a_byte_read: assert property (
    @(posedge sclk) disable iff (!rst_b)
    s_read_start |=> s_byte_out)
    else $error("byte read did not last eight clocks");
  a_ready_bit: assert property (
    @(posedge sclk) disable iff (!rst_b)
    (comm_done && comm_bits[6:3] == 4'h1) |=> (dout == $past(to_link_s[1])))
    else $error("comms read does not lead with the ready flag");
  a_ones_reset: assert property (
    @(posedge sclk) disable iff (!rst_b)
    ones_hit |=> (state_reg == ASR_ST_COMM && cnt_reg == 5'h00 && ones_reg == 6'h00))
    else $error("run of ones did not reset the interface");
  a_back_idle: assert property (
    @(posedge sclk) disable iff (!rst_b)
    (state_reg == ASR_ST_WR && cnt_reg == len_cur - 5'd1 && !ones_hit) |=>
      (state_reg == ASR_ST_COMM && cnt_reg == 5'h00))
    else $error("interface did not return to comms wait");
  a_mode_store: assert property (
    @(posedge sclk) disable iff (!rst_b)
    (state_reg == ASR_ST_WR && comm_reg[6:4] == `ASR_SEL_MODE && cnt_reg == 5'h07 && !ones_hit)
      |=> (mode_reg == $past(wr_word[7:0])))
    else $error("mode write not stored");
  a_chan_update: assert property (
    @(posedge sclk) disable iff (!rst_b)
    $changed(comm_reg[2:0]) |-> $past(comm_done))
    else $error("channel changed outside a comms write");

  // config toggle and data-read toggle into core domain
  asr_sync #(.W(2)) u_sync_core (
    .clk      (mclk),
    .rst_b    (rst_b),
    .d        ({rd_tgl_reg, cfg_tgl_reg}),
    .sync_reg (to_core_s)
  );

  // apb slave, result mailbox, ready flag and config mirror
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign mapped = (paddr == `ASR_OFS_RESULT) || (paddr == `ASR_OFS_CONFIG) ||
                  (paddr == `ASR_OFS_STATUS) || (paddr == `ASR_OFS_CALZERO) ||
                  (paddr == `ASR_OFS_CALFULL);

  always_comb begin
    pready_next   = setup;
    pslverr_next  = setup && !mapped;
    prdata_next   = 32'h00000000;
    res_next      = res_reg;
    res_tgl_next  = res_tgl_reg;
    ready_n_next  = conversion_ready_flag_n;
    seen_cfg_next = seen_cfg_reg;
    seen_rd_next  = seen_rd_reg;
    chan_next     = cfg_channel;
    cmode_next    = cfg_mode;
    cfhi_next     = cfg_filter_hi;
    cflo_next     = cfg_filter_lo;
    czero_next    = cfg_cal_zero;
    cfull_next    = cfg_cal_full;
    if (setup && !pwrite) begin
      if (paddr == `ASR_OFS_RESULT) begin
        prdata_next = {8'h00, res_reg};
      end else if (paddr == `ASR_OFS_CONFIG) begin
        prdata_next = {cfg_filter_lo, cfg_filter_hi, cfg_mode, 5'h00, cfg_channel};
      end else if (paddr == `ASR_OFS_STATUS) begin
        prdata_next = {28'h0000000, conversion_ready_flag_n, cfg_channel};
      end else if (paddr == `ASR_OFS_CALZERO) begin
        prdata_next = {8'h00, cfg_cal_zero};
      end else if (paddr == `ASR_OFS_CALFULL) begin
        prdata_next = {8'h00, cfg_cal_full};
      end
    end
    // serial data read consumed the result
    if (to_core_s[1] != seen_rd_reg) begin
      seen_rd_next = to_core_s[1];
      ready_n_next = 1'b1;
    end
    // a new result wins over a same-cycle consume
    if (access && pwrite && paddr == `ASR_OFS_RESULT) begin
      res_next     = pwdata[23:0];
      res_tgl_next = ~res_tgl_reg;
      ready_n_next = 1'b0;
    end
    // serial side has settled registers, copy them
    if (to_core_s[0] != seen_cfg_reg) begin
      seen_cfg_next = to_core_s[0];
      chan_next     = comm_reg[2:0];
      cmode_next    = mode_reg;
      cfhi_next     = fhi_reg;
      cflo_next     = flo_reg;
      czero_next    = zcal_reg[pair_cur];
      cfull_next    = fcal_reg[pair_cur];
    end
  end

  // core domain registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata                  <= 32'h00000000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      res_reg                 <= `ASR_RST_RESULT;
      res_tgl_reg             <= 1'b0;
      conversion_ready_flag_n <= 1'b1;
      seen_cfg_reg            <= 1'b0;
      seen_rd_reg             <= 1'b0;
      cfg_channel             <= 3'(`ASR_RST_COMM);
      cfg_mode                <= `ASR_RST_MODE;
      cfg_filter_hi           <= `ASR_RST_FILT_HI;
      cfg_filter_lo           <= `ASR_RST_FILT_LO;
      cfg_cal_zero            <= `ASR_RST_CAL;
      cfg_cal_full            <= `ASR_RST_CAL;
    end else begin
      prdata                  <= prdata_next;
      pready                  <= pready_next;
      pslverr                 <= pslverr_next;
      res_reg                 <= res_next;
      res_tgl_reg             <= res_tgl_next;
      conversion_ready_flag_n <= ready_n_next;
      seen_cfg_reg            <= seen_cfg_next;
      seen_rd_reg             <= seen_rd_next;
      cfg_channel             <= chan_next;
      cfg_mode                <= cmode_next;
      cfg_filter_hi           <= cfhi_next;
      cfg_filter_lo           <= cflo_next;
      cfg_cal_zero            <= czero_next;
      cfg_cal_full            <= cfull_next;
    end
  end

  a_result_ready: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (access && pwrite && paddr == `ASR_OFS_RESULT) |=> !conversion_ready_flag_n)
    else $error("result write did not assert ready");
  a_unmapped_err: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (setup && !mapped) |=> (pready && pslverr && prdata == 32'h00000000))
    else $error("unmapped access not answered with error");

endmodule

`default_nettype wire

//--- logic/asr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module asr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] sync_reg
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  // two-stage shift, first stage feeds only the second
  always_comb begin
    meta_next = d;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

endmodule

`default_nettype wire

//--- sim/adc_serial_register_access_bench.sv
`include "asr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_serial_register_access_bench;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic        sclk, din, dout, ready_n;
  logic [2:0]  cfg_channel;
  logic [7:0]  cfg_mode, cfg_filter_hi, cfg_filter_lo;
  logic [23:0] cfg_cal_zero, cfg_cal_full;
  int          fail_count, check_count, cyc, ch, res, rdy;
  int          mdl[8], calz[3], calf[3];

  asr_serial_regs #(.AW(12)) uut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .din(din), .dout(dout),
    .conversion_ready_flag_n(ready_n), .cfg_channel(cfg_channel),
    .cfg_mode(cfg_mode), .cfg_filter_hi(cfg_filter_hi), .cfg_filter_lo(cfg_filter_lo),
    .cfg_cal_zero(cfg_cal_zero), .cfg_cal_full(cfg_cal_full)
  );

  asr_host_model host (.sclk(sclk), .din(din), .dout(dout));

  // 50 mhz core clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // channel to calibration pair
  function automatic int pair(int c);
    return (c == 0 || c == 4) ? 0 : (c == 1 || c == 5) ? 1 : 2;
  endfunction

  function automatic int len(int s);
    return s < 5 ? 8 : (s == 5 && mdl[2][6] == 1'b0) ? 16 : 24;
  endfunction

  // value a serial read should return
  function automatic int exp_rd(int s);
    case (s)
      0: return rdy * 128 + 8 + ch;
      5: return mdl[2][6] ? res : res >> 8;
      6: return calz[pair(ch)];
      7: return calf[pair(ch)];
      default: return mdl[s];
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // comms write then selected access in one frame
  task automatic acc(input logic rw, input int s, input int c, input int d);
    int n;
    logic [31:0] w, r, m;
    n = (s == 0 && rw == 1'b0) ? 0 : len(s);
    m = (32'h1 << n) - 1;
    w = ({24'h0, 1'b0, 3'(s), rw, 3'(c)} << n) | (32'(d) & m);
    ch = c;
    host.shift(8 + n, w, r);
    if (rw) begin
      check("serial read", (r >> 1) & m, exp_rd(s));
      check("dout idle", r[0], 32'h1);
      if (s == 5) rdy = 1;
    end
    else if (s >= 1 && s <= 4) mdl[s] = d & 8'hff;
    else if (s == 6) calz[pair(c)] = d & 24'hffffff;
    else if (s == 7) calf[pair(c)] = d & 24'hffffff;
  endtask

  // mclk side copies and apb views against the model
  task automatic cfgchk();
    logic [31:0] rd;
    logic er;
    repeat (10) @(posedge mclk);
    check("cfg_channel", cfg_channel, ch);
    check("cfg_mode", cfg_mode, mdl[1]);
    check("cfg_filter_hi", cfg_filter_hi, mdl[2]);
    check("cfg_filter_lo", cfg_filter_lo, mdl[3]);
    check("cfg_cal_zero", cfg_cal_zero, calz[pair(ch)]);
    check("cfg_cal_full", cfg_cal_full, calf[pair(ch)]);
    check("ready_n", ready_n, rdy);
    apb(1'b0, `ASR_OFS_CONFIG, 32'h0, rd, er);
    check("config", rd, (mdl[3] << 24) | (mdl[2] << 16) | (mdl[1] << 8) | ch);
    apb(1'b0, `ASR_OFS_STATUS, 32'h0, rd, er);
    check("status", rd, rdy * 8 + ch);
    check("pslverr", er, 32'h0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'd52274;
    ch = 4;
    rdy = 1;
    host.shift(4, 32'hf, q);
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    check("dout reset", dout, 32'h1);
    cfgchk();
    acc(1'b1, 0, 4, 0);
    $display("test reset done");
    for (int s = 1; s <= 4; s++) acc(1'b0, s, rnd() & 7, rnd() & (s == 2 ? 8'hbf : 8'hff));
    for (int s = 0; s <= 4; s++) acc(1'b1, s, ch, 0);
    cfgchk();
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      acc(1'b0, 2, ch, (mdl[2] & 8'hbf) | (k << 6));
      res = rnd() & 24'hffffff;
      apb(1'b1, `ASR_OFS_RESULT, res, q, e);
      rdy = 0;
      apb(1'b0, `ASR_OFS_RESULT, 32'h0, q, e);
      check("result", q, res);
      cfgchk();
      acc(1'b1, 0, ch, 0);
      acc(1'b0, 5, ch, rnd());
      acc(1'b1, 5, ch, 0);
      cfgchk();
    end
    $display("test data done");
    for (int c = 0; c < 3; c++) begin
      acc(1'b0, 6, c, rnd());
      acc(1'b0, 7, c, rnd());
    end
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 6, c, 0);
      acc(1'b1, 7, c, 0);
      cfgchk();
      apb(1'b0, `ASR_OFS_CALZERO, 32'h0, q, e);
      check("calzero", q, calz[pair(c)]);
      apb(1'b0, `ASR_OFS_CALFULL, 32'h0, q, e);
      check("calfull", q, calf[pair(c)]);
    end
    $display("test calibration done");
    host.shift(5, 32'h1f, q);
    acc(1'b0, 1, ch, rnd() & 8'hff);
    acc(1'b1, 1, ch, 0);
    host.shift(32, 32'h7fffffff, q);
    host.shift(32, 32'hffffffff, q);
    host.shift(9, 32'h1ff, q);
    acc(1'b1, 1, 7, 0);
    $display("test resync done");
    apb(1'b0, 12'h014, 32'h0, q, e);
    check("unmapped data", q, 32'h0);
    check("unmapped err", e, 32'h1);
    apb(1'b1, `ASR_OFS_CONFIG, rnd(), q, e);
    acc(1'b0, 0, 2, 0);
    cfgchk();
    $display("test apb done");
    results();
  end
endmodule

`default_nettype wire

//--- sim/asr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the serial port; sclk only toggles inside frames
module asr_host_model (
  output var logic sclk,
  output var logic din,
  input  wire logic dout
);
  // idle levels
  initial begin
    sclk = 1'b0;
    din  = 1'b1;
  end

  // shift n bits msb first, dout taken at each falling edge
  task automatic shift(input int n, input logic [31:0] w, output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      din <= w[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      r = {r[30:0], dout};
    end
  endtask
endmodule

`default_nettype wire
